// [energy_accum_regs.vh]
// register map, field positions, reset values and timing counts of the energy accumulator
`ifndef ENERGY_ACCUM_REGS_VH
`define ENERGY_ACCUM_REGS_VH

// ************************************************************
// register word addresses
// ************************************************************
`define ADDR_THR_HIGH          8'h00
`define ADDR_THR_LOW           8'h01
`define ADDR_PHASE_A_ENERGY    8'h02
`define ADDR_PHASE_B_ENERGY    8'h03
`define ADDR_PHASE_C_ENERGY    8'h04
`define ADDR_FLAGS             8'h05
`define ADDR_ENABLES           8'h06
`define ADDR_LINE_CYCLE_CFG    8'h07
`define ADDR_ACCUM_CFG         8'h08
`define ADDR_HALF_CYCLE_COUNT  8'h09
`define ADDR_POWER_SIGN        8'h0a

// ************************************************************
// field positions
// ************************************************************
`define FLAG_HALF_FULL_BIT     0
`define FLAG_LINE_DONE_BIT     5
`define FLAG_SIGN_A_BIT        6
`define LCFG_LINE_ENABLE_BIT   0
`define LCFG_ZX_C_BIT          3
`define LCFG_ZX_B_BIT          4
`define LCFG_ZX_A_BIT          5
`define LCFG_READ_CLEAR_BIT    6
`define ACFG_SIGN_MODE_LSB     0
`define ACFG_COMBINE_LSB       4
`define THR_WORD_BITS          24

// ************************************************************
// phase b combination codes
// ************************************************************
`define COMBINE_OWN            2'h0
`define COMBINE_ZERO           2'h1
`define COMBINE_MINUS_A_C      2'h2
`define COMBINE_MINUS_A        2'h3

// ************************************************************
// reset values
// ************************************************************
`define RESET_THR              48'h000000000000
`define RESET_ENABLES          32'h00000000
`define RESET_LINE_CYCLE_CFG   8'h00
`define RESET_ACCUM_CFG        8'h00
`define RESET_HALF_CYCLE_COUNT 16'h0000

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS          4
`define SAMPLE_PERIOD_NS       125000
`define SAMPLE_CYCLES          (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// [active_energy_accumulator.v]
// per-phase two-stage active energy accumulator with line-cycle mode and register port
`timescale 1ns/10ps
`default_nettype none
`include "energy_accum_regs.vh"

// Operation
// - every 125 us each phase power sample is added into its first-stage accumulator.
// - at threshold emit one pulse and subtract threshold, keeping the remainder.
// - sign of first-stage energy at pulse time gives the phase power sign.
// - pulses counted into 32-bit accumulators, read live in continuous mode, latched at period end in line mode.
// - one 48-bit threshold, software written, shared by all three phases.
// - threshold seen as high and low words, 24 bits each, top 8 zero.
// - energy counting is signed: negative pulses decrement, positive pulses increment.
// - energy registers wrap naturally in both directions at 32 bits.
// - status bit 0 set when a counted pulse, not a clear, changes bit 30 of any energy register.
// - enabled half-full condition drives the interrupt line low.
// - writing one to a status bit clears it and releases the line.
// - read-clear bit 6 zeroes each energy register after it is read, only while line-cycle mode is off.
// - bits 5..4 pick phase b input: own, zero, minus a minus c, minus a.
// - bits 1..0 steer only the pulse output sign mode, energy stays signed.
// - line-cycle mode transfers energy only after programmed zero crossings.
// - half-cycle count is 16-bit unsigned, up to 65535 crossings.
// - bits 5, 4, 3 include phase a, b, c crossings in the count.
// - crossing counter always runs; count write in line mode resets it.
// - end of line-cycle period sets status bit 5, interrupts when enabled.
// - line-cycle mode uses the same path and scaling as continuous mode.
// - sign bits 2..0 update together with the sign change flags.
module active_energy_accumulator #(
  parameter SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire [23:0] power_a,
  input  wire [23:0] power_b,
  input  wire [23:0] power_c,
  input  wire [23:0] power_va_ib,
  input  wire [23:0] power_vc_ib,
  input  wire        zero_cross_a,
  input  wire        zero_cross_b,
  input  wire        zero_cross_c,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg  [2:0]  energy_pulse,
  output reg  [2:0]  energy_pulse_negative,
  output reg  [1:0]  pulse_output_sign_mode,
  output reg         interrupt_request_line_n
);

  localparam [31:0] SAMPLE_LAST_FULL = SAMPLE_CYCLES - 1;
  localparam [15:0] SAMPLE_LAST      = SAMPLE_LAST_FULL[15:0];

  // ************************************************************
  // configuration registers
  // ************************************************************
  reg  [47:0] energy_threshold_reg;
  reg  [31:0] interrupt_enable_word_reg;
  reg  [7:0]  line_cycle_config_reg;
  reg  [7:0]  accumulation_config_reg;
  reg  [15:0] half_cycle_count_reg;
  reg  [31:0] interrupt_flags_word_reg;
  reg  [2:0]  power_sign_reg;

  wire        line_cycle_energy_enable = line_cycle_config_reg[`LCFG_LINE_ENABLE_BIT];
  wire        read_clear_enable        = line_cycle_config_reg[`LCFG_READ_CLEAR_BIT];
  wire [1:0]  phase_combination_select = accumulation_config_reg[`ACFG_COMBINE_LSB+1:`ACFG_COMBINE_LSB];

  wire wr_thr_high = reg_wr && (reg_addr == `ADDR_THR_HIGH);
  wire wr_thr_low  = reg_wr && (reg_addr == `ADDR_THR_LOW);
  wire wr_flags    = reg_wr && (reg_addr == `ADDR_FLAGS);
  wire wr_enables  = reg_wr && (reg_addr == `ADDR_ENABLES);
  wire wr_lcfg     = reg_wr && (reg_addr == `ADDR_LINE_CYCLE_CFG);
  wire wr_acfg     = reg_wr && (reg_addr == `ADDR_ACCUM_CFG);
  wire wr_halfcyc  = reg_wr && (reg_addr == `ADDR_HALF_CYCLE_COUNT);
  wire line_restart = wr_halfcyc && line_cycle_energy_enable;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      energy_threshold_reg      <= `RESET_THR;
      interrupt_enable_word_reg <= `RESET_ENABLES;
      line_cycle_config_reg     <= `RESET_LINE_CYCLE_CFG;
      accumulation_config_reg   <= `RESET_ACCUM_CFG;
      half_cycle_count_reg      <= `RESET_HALF_CYCLE_COUNT;
      pulse_output_sign_mode    <= 2'h0;
    end else begin
      if (wr_thr_high) begin
        energy_threshold_reg[47:24] <= reg_wdata[23:0];
      end
      if (wr_thr_low) begin
        energy_threshold_reg[23:0] <= reg_wdata[23:0];
      end
      if (wr_enables) begin
        interrupt_enable_word_reg <= reg_wdata;
      end
      if (wr_lcfg) begin
        line_cycle_config_reg <= reg_wdata[7:0];
      end
      if (wr_acfg) begin
        accumulation_config_reg <= reg_wdata[7:0];
        pulse_output_sign_mode  <= reg_wdata[`ACFG_SIGN_MODE_LSB+1:`ACFG_SIGN_MODE_LSB];
      end
      if (wr_halfcyc) begin
        half_cycle_count_reg <= reg_wdata[15:0];
      end
    end
  end

  // ************************************************************
  // sample rate divider
  // ************************************************************
  // one-cycle tick per sample period
  reg  [15:0] sample_cnt_reg;
  reg         sample_tick_reg;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sample_cnt_reg  <= 16'h0000;
      sample_tick_reg <= 1'b0;
    end else if (sample_cnt_reg == SAMPLE_LAST) begin
      sample_cnt_reg  <= 16'h0000;
      sample_tick_reg <= 1'b1;
    end else begin
      sample_cnt_reg  <= sample_cnt_reg + 16'h0001;
      sample_tick_reg <= 1'b0;
    end
  end

  // ************************************************************
  // phase b input selection
  // ************************************************************
  // codes 2 and 3 rebuild phase b from the other products
  reg  [23:0] phase_b_sel;

  always @* begin
    case (phase_combination_select)
      `COMBINE_OWN:       phase_b_sel = power_b;
      `COMBINE_ZERO:      phase_b_sel = 24'h000000;
      `COMBINE_MINUS_A_C: phase_b_sel = 24'h000000 - power_va_ib - power_vc_ib;
      default:            phase_b_sel = 24'h000000 - power_va_ib;
    endcase
  end

  wire [71:0] phase_power = {power_c, phase_b_sel, power_a};

  // ************************************************************
  // zero-crossing counter for line-cycle mode
  // ************************************************************
  reg  [15:0] zx_cnt_reg;
  reg         line_end_reg;

  wire [1:0]  zx_inc = {1'b0, zero_cross_a & line_cycle_config_reg[`LCFG_ZX_A_BIT]}
                     + {1'b0, zero_cross_b & line_cycle_config_reg[`LCFG_ZX_B_BIT]}
                     + {1'b0, zero_cross_c & line_cycle_config_reg[`LCFG_ZX_C_BIT]};
  wire [16:0] zx_sum = {1'b0, zx_cnt_reg} + {15'h0000, zx_inc};
  // a zero count never ends a period
  wire        zx_done = (half_cycle_count_reg != 16'h0000)
                     && (zx_sum >= {1'b0, half_cycle_count_reg});

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      zx_cnt_reg   <= 16'h0000;
      line_end_reg <= 1'b0;
    end else if (line_restart) begin
      zx_cnt_reg   <= 16'h0000;
      line_end_reg <= 1'b0;
    end else if (zx_done) begin
      zx_cnt_reg   <= 16'h0000;
      line_end_reg <= line_cycle_energy_enable;
    end else begin
      zx_cnt_reg   <= zx_sum[15:0];
      line_end_reg <= 1'b0;
    end
  end

  // ************************************************************
  // per-phase two-stage accumulation
  // ************************************************************
  wire [49:0] thr_ext = {2'b00, energy_threshold_reg};
  wire [2:0]  half_full_evt;
  wire [2:0]  sign_change_evt;
  wire [2:0]  sign_next;
  wire [95:0] energy_live;
  wire [95:0] energy_view;
  wire [2:0]  pulse_next;
  wire [2:0]  pulse_neg_next;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : phase
      localparam [31:0] ENERGY_ADDR_FULL = `ADDR_PHASE_A_ENERGY + g;
      localparam [7:0]  ENERGY_ADDR      = ENERGY_ADDR_FULL[7:0];
      // two spare bits keep the sum and its negation from overflowing
      reg  [49:0] stage1_reg;
      reg  [31:0] energy_acc_reg;
      reg  [31:0] energy_view_reg;
      reg         sign_reg;
      reg         sign_evt_reg;
      wire [23:0] p_in   = phase_power[24*g+23:24*g];
      wire [49:0] sum    = stage1_reg + {{26{p_in[23]}}, p_in};
      wire        pos_hit = ~sum[49] && (sum >= thr_ext);
      wire        neg_hit = sum[49] && ((50'h0 - sum) >= thr_ext);
      wire        read_hit = reg_rd && (reg_addr == ENERGY_ADDR);
      wire        clr = (read_hit && read_clear_enable && !line_cycle_energy_enable)
                      || line_end_reg || line_restart;
      wire [31:0] delta = energy_pulse[g]
                          ? (energy_pulse_negative[g] ? 32'hffffffff : 32'h00000001)
                          : 32'h00000000;
      wire [31:0] acc_plus = energy_acc_reg + delta;
      wire [31:0] acc_next = clr ? delta : acc_plus;

      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          stage1_reg   <= 50'h0;
          sign_reg     <= 1'b0;
          sign_evt_reg <= 1'b0;
        end else begin
          sign_evt_reg <= 1'b0;
          if (sample_tick_reg && pos_hit) begin
            stage1_reg   <= sum - thr_ext;
            sign_reg     <= 1'b0;
            sign_evt_reg <= sign_reg;
          end else if (sample_tick_reg && neg_hit) begin
            stage1_reg   <= sum + thr_ext;
            sign_reg     <= 1'b1;
            sign_evt_reg <= ~sign_reg;
          end else if (sample_tick_reg) begin
            stage1_reg <= sum;
          end
        end
      end

      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          energy_acc_reg  <= 32'h00000000;
          energy_view_reg <= 32'h00000000;
        end else begin
          energy_acc_reg <= acc_next;
          if (line_end_reg) begin
            energy_view_reg <= acc_plus;
          end else if (read_hit && !line_cycle_energy_enable) begin
            energy_view_reg <= acc_plus;
          end
        end
      end

      // a period restart hides the bit 30 step
      assign half_full_evt[g]     = energy_pulse[g] && !clr
                                  && (acc_plus[30] != energy_acc_reg[30]);
      assign sign_change_evt[g]   = sign_evt_reg;
      assign sign_next[g]         = sign_reg;
      assign pulse_next[g]        = sample_tick_reg && (pos_hit || neg_hit);
      assign pulse_neg_next[g]    = sample_tick_reg && !pos_hit && neg_hit;
      assign energy_live[32*g+31:32*g] = acc_plus;
      assign energy_view[32*g+31:32*g] = energy_view_reg;
    end
  endgenerate

  // ************************************************************
  // energy pulse outputs
  // ************************************************************
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      energy_pulse          <= 3'h0;
      energy_pulse_negative <= 3'h0;
    end else begin
      energy_pulse          <= pulse_next;
      energy_pulse_negative <= pulse_neg_next;
    end
  end

  // ************************************************************
  // status flags, sign word and interrupt line
  // ************************************************************
  reg  [31:0] flag_set;

  always @* begin
    flag_set = 32'h00000000;
    flag_set[`FLAG_HALF_FULL_BIT] = |half_full_evt;
    flag_set[`FLAG_LINE_DONE_BIT] = line_end_reg;
    flag_set[`FLAG_SIGN_A_BIT+2:`FLAG_SIGN_A_BIT] = sign_change_evt;
  end

  wire [31:0] flags_next = (interrupt_flags_word_reg & ~(wr_flags ? reg_wdata : 32'h0))
                         | flag_set;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_flags_word_reg <= 32'h00000000;
      power_sign_reg           <= 3'h0;
      interrupt_request_line_n <= 1'b1;
    end else begin
      interrupt_flags_word_reg <= flags_next;
      if (|sign_change_evt) begin
        power_sign_reg <= sign_next;
      end
      interrupt_request_line_n <= ~|(flags_next & interrupt_enable_word_reg);
    end
  end

  // ************************************************************
  // register read port
  // ************************************************************
  // line mode serves the latched view, otherwise the live count
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == `ADDR_THR_HIGH) begin
        reg_rdata <= {8'h00, energy_threshold_reg[47:24]};
      end else if (reg_addr == `ADDR_THR_LOW) begin
        reg_rdata <= {8'h00, energy_threshold_reg[23:0]};
      end else if (reg_addr == `ADDR_PHASE_A_ENERGY) begin
        reg_rdata <= line_cycle_energy_enable ? energy_view[31:0] : energy_live[31:0];
      end else if (reg_addr == `ADDR_PHASE_B_ENERGY) begin
        reg_rdata <= line_cycle_energy_enable ? energy_view[63:32] : energy_live[63:32];
      end else if (reg_addr == `ADDR_PHASE_C_ENERGY) begin
        reg_rdata <= line_cycle_energy_enable ? energy_view[95:64] : energy_live[95:64];
      end else if (reg_addr == `ADDR_FLAGS) begin
        reg_rdata <= interrupt_flags_word_reg;
      end else if (reg_addr == `ADDR_ENABLES) begin
        reg_rdata <= interrupt_enable_word_reg;
      end else if (reg_addr == `ADDR_LINE_CYCLE_CFG) begin
        reg_rdata <= {24'h000000, line_cycle_config_reg};
      end else if (reg_addr == `ADDR_ACCUM_CFG) begin
        reg_rdata <= {24'h000000, accumulation_config_reg};
      end else if (reg_addr == `ADDR_HALF_CYCLE_COUNT) begin
        reg_rdata <= {16'h0000, half_cycle_count_reg};
      end else if (reg_addr == `ADDR_POWER_SIGN) begin
        reg_rdata <= {29'h00000000, power_sign_reg};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

endmodule // active_energy_accumulator
`default_nettype wire

// [host_model.sv]
// register port master standing in for the host controller
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        sys_clk,
  output var  logic [7:0]  reg_addr,
  output var  logic [31:0] reg_wdata,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  input  wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  task wr(input [7:0] a, input [31:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task rd(input [7:0] a, output [31:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    d      = reg_rdata;
  endtask
  // top bit never set, threshold stays non-negative
  task set_thr(input [47:0] t);
    wr(8'h00, {8'h00, 1'b0, t[46:24]});
    wr(8'h01, {8'h00, t[23:0]});
  endtask
  // read-clear kept off while counting half cycles
  task line_mode(input [2:0] zx, input [15:0] n);
    wr(8'h07, {24'h0, 2'h0, zx, 3'h1});
    wr(8'h09, {16'h0, n});
  endtask
  task clear_flags(input [31:0] m);
    wr(8'h05, m);
  endtask
endmodule // host_model
`default_nettype wire

// [energy_accum_props.sv]
// port assertions for the energy accumulator
`timescale 1ns/10ps
`default_nettype none
module energy_accum_props #(
  parameter SAMPLE_CYCLES = 8
) (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [2:0]  zero_cross,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [2:0]  energy_pulse,
  input wire logic [1:0]  pulse_output_sign_mode,
  input wire logic        interrupt_request_line_n
);
  reg [31:0] gap_reg;
  reg [31:0] en_reg;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gap_reg <= 32'h0000ffff;
      en_reg  <= 32'h0;
    end else begin
      gap_reg <= energy_pulse[0] ? 32'h0 : gap_reg + 32'h1;
      if (reg_wr && reg_addr == 8'h06)
        en_reg <= reg_wdata;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence calm_s;
    energy_pulse == 3'h0 && zero_cross == 3'h0;
  endsequence
  sequence clear_all_s;
    reg_wr && reg_addr == 8'h05 && reg_wdata == 32'hffffffff;
  endsequence
  a_pulse_tick_spacing: assert property (energy_pulse[0] |-> gap_reg >= SAMPLE_CYCLES - 1)
    else $error("phase pulses closer than one sample period");
  a_pulse_one_cycle: assert property (energy_pulse[1] |=> !energy_pulse[1])
    else $error("energy pulse longer than one cycle");
  a_irq_needs_enable: assert property ((en_reg == 32'h0) [*2] |-> interrupt_request_line_n)
    else $error("interrupt line low with all sources disabled");
  a_clear_releases_irq: assert property (calm_s [*4] ##0 clear_all_s |-> ##1 interrupt_request_line_n)
    else $error("interrupt line still low after clearing all flags");
  a_irq_idle_reset: assert property ($rose(resetn) |-> interrupt_request_line_n)
    else $error("interrupt line low right after reset");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_unmapped_reads_zero: assert property (reg_rd && reg_addr > 8'h0a |=> reg_rdata == 32'h0)
    else $error("unmapped read returned nonzero");
  a_thr_top_zero: assert property (reg_rd && reg_addr < 8'h02 |=> reg_rdata[31:24] == 8'h00)
    else $error("threshold word top byte not zero");
  a_sign_mode_follows: assert property (reg_wr && reg_addr == 8'h08 |=>
    pulse_output_sign_mode == $past(reg_wdata[1:0]))
    else $error("sign mode output does not follow configuration");
endmodule // energy_accum_props
bind active_energy_accumulator energy_accum_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_props (
  .sys_clk(sys_clk), .resetn(resetn),
  .zero_cross({zero_cross_c, zero_cross_b, zero_cross_a}),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .energy_pulse(energy_pulse),
  .pulse_output_sign_mode(pulse_output_sign_mode),
  .interrupt_request_line_n(interrupt_request_line_n));
`default_nettype wire

// [testbench.sv]
// self-checking bench for the energy accumulator
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [23:0] pw [0:4] = '{default: 24'h0};
  logic [2:0]  zx = 3'h0;
  wire  [7:0]  reg_addr;
  wire  [31:0] reg_wdata;
  wire  [31:0] reg_rdata;
  wire         reg_wr;
  wire         reg_rd;
  wire         irq_n;
  wire  [2:0]  pulse;
  wire  [2:0]  pulse_neg;
  wire  [1:0]  mode;
  integer      n_mismatch = 0;
  integer      num_checks = 0;
  integer      cycles = 0;
  integer      np [0:2] = '{default: 0};
  integer      nn [0:2] = '{default: 0};
  logic [31:0] v, w, a0, c0;
  active_energy_accumulator #(.SAMPLE_CYCLES(8)) i_active_energy_accumulator (
    .sys_clk(sys_clk), .resetn(resetn), .power_a(pw[0]), .power_b(pw[1]), .power_c(pw[2]),
    .power_va_ib(pw[3]), .power_vc_ib(pw[4]), .zero_cross_a(zx[0]), .zero_cross_b(zx[1]),
    .zero_cross_c(zx[2]), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .energy_pulse(pulse),
    .energy_pulse_negative(pulse_neg), .pulse_output_sign_mode(mode),
    .interrupt_request_line_n(irq_n));
  host_model i_host_model (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    for (int i = 0; i < 3; i++) begin
      np[i] = np[i] + (pulse[i] & !pulse_neg[i]);
      nn[i] = nn[i] + (pulse[i] & pulse_neg[i]);
    end
    if (cycles == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task zx_pulse(input [2:0] m);
    @(posedge sys_clk);
    #1;
    zx = m;
    @(posedge sys_clk);
    #1;
    zx = 3'h0;
    repeat (12) @(posedge sys_clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset_values;
    for (int a = 0; a < 12; a++) begin
      if (a < 2 || (a > 5 && a < 10) || a == 11) begin
        i_host_model.rd(a[7:0], v);
        chk(v, 32'h0);
      end
    end
    i_host_model.wr(8'h09, 32'hffffffff);
    i_host_model.rd(8'h09, v);
    chk(v, 32'h0000ffff);
  endtask
  task t_threshold_words;
    i_host_model.wr(8'h00, 32'hffabcdef);
    i_host_model.wr(8'h01, 32'h98765432);
    i_host_model.rd(8'h00, v);
    chk(v, 32'h00abcdef);
    i_host_model.rd(8'h01, v);
    chk(v, 32'h00765432);
    i_host_model.set_thr(48'h64);
    i_host_model.rd(8'h01, v);
    chk(v, 32'h64);
  endtask
  task t_signed_count;
    i_host_model.rd(8'h02, a0);
    i_host_model.rd(8'h04, c0);
    pw[0] = 24'h64;
    pw[2] = 24'hffff9c;
    repeat (80) @(posedge sys_clk);
    #1;
    pw[0] = 24'h0;
    pw[2] = 24'h0;
    repeat (16) @(posedge sys_clk);
    i_host_model.rd(8'h02, v);
    chk(v - a0, 32'ha);
    i_host_model.rd(8'h04, v);
    chk(v - c0, 32'hfffffff6);
    i_host_model.rd(8'h0a, v);
    chk(v & 32'h7, 32'h4);
    i_host_model.rd(8'h05, v);
    chk(v & 32'h1c0, 32'h100);
    chk({31'h0, irq_n}, 32'h1);
  endtask
  task t_read_clear;
    i_host_model.wr(8'h07, 32'h40);
    i_host_model.rd(8'h02, v);
    chk(v, a0 + 32'ha);
    i_host_model.rd(8'h02, v);
    chk(v, 32'h0);
    i_host_model.wr(8'h07, 32'h0);
    i_host_model.clear_flags(32'hffffffff);
    i_host_model.rd(8'h05, v);
    chk(v, 32'h0);
  endtask
  task t_combine;
    integer p, q;
    pw[1] = 24'h64;
    pw[3] = 24'h64;
    pw[4] = 24'h64;
    for (int c = 0; c < 4; c++) begin
      i_host_model.wr(8'h08, {24'h0, 2'h0, c[1:0], 2'h0, c[1:0]});
      // let a pulse launched under the old code be counted first
      repeat (2) @(posedge sys_clk);
      #1;
      p = np[1];
      q = nn[1];
      repeat (40) @(posedge sys_clk);
      #1;
      chk({30'h0, mode}, {30'h0, c[1:0]});
      chk(32'(np[1] > p), 32'(c == 0));
      chk(32'(nn[1] > q), 32'(c > 1));
    end
    i_host_model.wr(8'h08, 32'h0);
    pw[1] = 24'h0;
    pw[3] = 24'h0;
    pw[4] = 24'h0;
  endtask
  task t_line_mode;
    i_host_model.wr(8'h06, 32'h20);
    i_host_model.clear_flags(32'hffffffff);
    pw[0] = 24'h64;
    i_host_model.line_mode(3'h4, 16'h3);
    zx_pulse(3'h2);
    zx_pulse(3'h2);
    zx_pulse(3'h1);
    zx_pulse(3'h1);
    i_host_model.rd(8'h05, v);
    chk(v & 32'h20, 32'h0);
    chk({31'h0, irq_n}, 32'h1);
    zx_pulse(3'h1);
    i_host_model.rd(8'h05, v);
    chk(v & 32'h20, 32'h20);
    chk({31'h0, irq_n}, 32'h0);
    i_host_model.rd(8'h02, v);
    chk({31'h0, (v == 32'h7) || (v == 32'h8)}, 32'h1);
    repeat (40) @(posedge sys_clk);
    i_host_model.rd(8'h02, w);
    chk(w, v);
    i_host_model.clear_flags(32'h20);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({31'h0, irq_n}, 32'h1);
    i_host_model.wr(8'h07, 32'h0);
    pw[0] = 24'h0;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    t_reset_values();
    t_threshold_words();
    t_signed_count();
    t_read_clear();
    t_combine();
    t_line_mode();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
